// ### inc/sltcu_pkg.sv
/*
  Shared constants and types for the scan logic, timer and counter unit.
  Assumes a single 125 MHz clock domain and a program sequencer outside.
*/
package sltcu_pkg;

  // Clock rate and interval base
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;

  // Operand limits, byte.bit for bits and word index for words
  localparam logic [2:0] IO_BIT_MAX     = 3'h3;
  localparam logic [2:0] MEM_BYTE_MAX   = 3'h5;
  localparam logic [2:0] FLAG_BYTE_MAX  = 3'h1;
  localparam logic [2:0] TC_NUM_MAX     = 3'h3;
  localparam logic [2:0] WSTORE_MAX     = 3'h4;
  localparam logic [2:0] PWORD_MAX      = 3'h2;
  localparam int unsigned EDGE_SLOTS     = 32;
  localparam int unsigned NUM_TC         = 4;
  localparam int unsigned STACK_DEPTH    = 9;

  // Value limits and reset values
  localparam logic [15:0] TIMER_MAX     = 16'h7FFF;
  localparam logic [15:0] WORD_RST      = 16'h0000;

  // Bit operand areas
  typedef enum logic [1:0] {SLTCU_A_IN, SLTCU_A_OUT, SLTCU_A_MEM, SLTCU_A_FLAG} sltcu_barea_t;

  // Word operand areas
  typedef enum logic [2:0] {SLTCU_W_TIM, SLTCU_W_CNT, SLTCU_W_STORE, SLTCU_W_PARAM,
                            SLTCU_W_CONST} sltcu_warea_t;

  // Operations
  typedef enum logic [4:0] {
    SLTCU_OP_LD, SLTCU_OP_AND, SLTCU_OP_OR, SLTCU_OP_LDN, SLTCU_OP_ANDN, SLTCU_OP_ORN,
    SLTCU_OP_NOT, SLTCU_OP_RISE, SLTCU_OP_FALL,
    SLTCU_OP_LDW_EQ, SLTCU_OP_LDW_GE, SLTCU_OP_LDW_LE,
    SLTCU_OP_AW_EQ, SLTCU_OP_AW_GE, SLTCU_OP_AW_LE,
    SLTCU_OP_OW_EQ, SLTCU_OP_OW_GE, SLTCU_OP_OW_LE,
    SLTCU_OP_OUT, SLTCU_OP_SET, SLTCU_OP_RST, SLTCU_OP_TIMER, SLTCU_OP_COUNT
  } sltcu_op_t;

endpackage

// ### verilog/sltcu_tick.sv
/*
  Free-running interval base: pulses once per interval and counts the
  intervals elapsed since the last scan start.
  Assumes scan_start is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module sltcu_tick #(
  parameter int unsigned TICK_CYCLES = sltcu_pkg::TICK_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        scan_start,
  output logic      [15:0] elapsed
);
  import sltcu_pkg::*;

  logic [31:0] div;
  logic [15:0] acc;
  logic        tick;

  assign tick = (div == TICK_CYCLES - 1);

  // Divider runs regardless of any timer enable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 32'h0;
    end else if (ce) begin
      div <= tick ? 32'h0 : div + 32'h1;
    end
  end

  // Intervals accumulated during the running scan; latched at scan start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc     <= 16'h0;
      elapsed <= 16'h0;
    end else if (ce) begin
      if (scan_start) begin
        elapsed <= acc + {15'h0, tick};
        acc     <= 16'h0;
      end else if (tick && acc != 16'hFFFF) begin
        acc <= acc + 16'h1;
      end
    end
  end
endmodule // sltcu_tick
`default_nettype wire

// ### verilog/sltcu_image.sv
/*
  Input image: samples the input pins through a three-stage synchroniser
  and refreshes the image only at scan start.
  Assumes in_pins are asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sltcu_image #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             scan_start,
  input  wire logic [WIDTH-1:0] in_pins,
  output logic      [WIDTH-1:0] in_image
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] stable;

  // Three-stage synchroniser, first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= in_pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes once the second and third stages agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stable <= '0;
    end else if (ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          stable[i] <= s3[i];
        end
      end
    end
  end

  // Image refresh only at scan start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      in_image <= '0;
    end else if (ce && scan_start) begin
      in_image <= stable;
    end
  end
endmodule // sltcu_image
`default_nettype wire

// ### verilog/sltcu_core.sv
/*
  Scan logic, timer and counter unit: executes one boolean, compare,
  output, timer or counter instruction per exec pulse.
  Assumes a sequencer that pulses scan_start once per scan, then issues
  instructions; each instruction takes one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sltcu_core #(
  parameter int unsigned TICK_CYCLES = sltcu_pkg::TICK_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  input  wire logic                   scan_start,
  input  wire logic                   exec,
  input  wire sltcu_pkg::sltcu_op_t   op,
  input  wire sltcu_pkg::sltcu_barea_t barea,
  input  wire logic [2:0]             bbyte,
  input  wire logic [2:0]             bbit,
  input  wire sltcu_pkg::sltcu_warea_t warea1,
  input  wire logic [2:0]             windex1,
  input  wire sltcu_pkg::sltcu_warea_t warea2,
  input  wire logic [2:0]             windex2,
  input  wire logic [15:0]            wconst,
  input  wire logic [4:0]             edge_slot,
  input  wire logic [3:0]             in_pins,
  input  wire logic [15:0]            flag_bits,
  input  wire logic [47:0]            parameter_words,
  output logic      [3:0]             out_bits,
  output logic      [47:0]            mem_bits,
  output logic                        stack_top,
  output logic                        operand_err,
  output logic      [63:0]            tc_values
);
  import sltcu_pkg::*;

  logic [3:0]        in_image;
  logic [15:0]       elapsed;
  logic [STACK_DEPTH-1:0] stack;
  logic [EDGE_SLOTS-1:0]  edge_mem;
  logic [15:0]       timer_val [NUM_TC];
  logic [15:0]       count_val [NUM_TC];
  logic [NUM_TC-1:0] up_prev;
  logic [NUM_TC-1:0] dn_prev;
  logic              bit_ok;
  logic              w1_ok;
  logic              w2_ok;
  logic              bit_val;
  logic [15:0]       w1;
  logic [15:0]       w2;
  logic              cmp_res;
  logic              contact;
  logic              next_top;
  logic              is_cmp;
  logic [16:0]       timer_sum;
  logic [1:0]        tc_idx;

  sltcu_image #(.WIDTH(4)) u_image (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .ce         (ce),
    .scan_start (scan_start),
    .in_pins    (in_pins),
    .in_image   (in_image)
  );

  // Interval base runs on its own, timers only read its count
  sltcu_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .ce         (ce),
    .scan_start (scan_start),
    .elapsed    (elapsed)
  );

  // Range check for a word operand of any area
  function automatic logic word_ok(input sltcu_warea_t a, input logic [2:0] i);
    unique case (a)
      SLTCU_W_TIM, SLTCU_W_CNT: word_ok = (i <= TC_NUM_MAX);
      SLTCU_W_STORE:            word_ok = (i <= WSTORE_MAX);
      SLTCU_W_PARAM:            word_ok = (i <= PWORD_MAX);
      SLTCU_W_CONST:            word_ok = 1'b1;
      default:                  word_ok = 1'b0;
    endcase
  endfunction

  // Word fetch; memory words overlay byte pairs of the memory bits
  function automatic logic [15:0] word_get(input sltcu_warea_t a, input logic [2:0] i,
                                           input logic [15:0] k);
    logic [1:0] n;
    n = i[1:0];
    unique case (a)
      SLTCU_W_TIM:   word_get = timer_val[n];
      SLTCU_W_CNT:   word_get = count_val[n];
      SLTCU_W_STORE: word_get = {mem_bits[{i, 3'h0} +: 8], mem_bits[{i + 3'h1, 3'h0} +: 8]};
      SLTCU_W_PARAM: word_get = parameter_words[{i[1:0], 4'h0} +: 16];
      SLTCU_W_CONST: word_get = k;
      default:       word_get = WORD_RST;
    endcase
  endfunction

  // Bit operand decode and fetch
  always_comb begin
    bit_ok  = 1'b0;
    bit_val = 1'b0;
    unique case (barea)
      SLTCU_A_IN: begin
        bit_ok  = (bbyte == 3'h0) && (bbit <= IO_BIT_MAX);
        bit_val = in_image[bbit[1:0]];
      end
      SLTCU_A_OUT: begin
        bit_ok  = (bbyte == 3'h0) && (bbit <= IO_BIT_MAX);
        bit_val = out_bits[bbit[1:0]];
      end
      SLTCU_A_MEM: begin
        bit_ok  = (bbyte <= MEM_BYTE_MAX);
        bit_val = mem_bits[{bbyte, bbit}];
      end
      SLTCU_A_FLAG: begin
        bit_ok  = (bbyte <= FLAG_BYTE_MAX);
        bit_val = flag_bits[{bbyte[0], bbit}];
      end
    endcase
  end

  assign w1_ok  = word_ok(warea1, windex1) && (warea1 != SLTCU_W_CONST);
  assign w2_ok  = word_ok(warea2, windex2);
  // Procedural fetch, so a stored word that changes behind the call is seen too
  always_comb begin
    w1 = word_get(warea1, windex1, wconst);
    w2 = word_get(warea2, windex2, wconst);
  end
  assign tc_idx = windex1[1:0];
  assign is_cmp = (op >= SLTCU_OP_LDW_EQ) && (op <= SLTCU_OP_OW_LE);

  // Signed compare of two words
  always_comb begin
    unique case (op)
      SLTCU_OP_LDW_EQ, SLTCU_OP_AW_EQ, SLTCU_OP_OW_EQ: cmp_res = (w1 == w2);
      SLTCU_OP_LDW_GE, SLTCU_OP_AW_GE, SLTCU_OP_OW_GE:
        cmp_res = ($signed(w1) >= $signed(w2));
      default: cmp_res = ($signed(w1) <= $signed(w2));
    endcase
  end

  assign contact = is_cmp ? cmp_res
                 : ((op >= SLTCU_OP_LDN) && (op <= SLTCU_OP_ORN)) ? ~bit_val
                 : bit_val;

  // New stack top for boolean ops
  always_comb begin
    next_top = stack[0];
    unique case (op)
      SLTCU_OP_LD, SLTCU_OP_LDN, SLTCU_OP_LDW_EQ, SLTCU_OP_LDW_GE, SLTCU_OP_LDW_LE:
        next_top = contact;
      SLTCU_OP_AND, SLTCU_OP_ANDN, SLTCU_OP_AW_EQ, SLTCU_OP_AW_GE, SLTCU_OP_AW_LE:
        next_top = stack[0] & contact;
      SLTCU_OP_OR, SLTCU_OP_ORN, SLTCU_OP_OW_EQ, SLTCU_OP_OW_GE, SLTCU_OP_OW_LE:
        next_top = stack[0] | contact;
      SLTCU_OP_NOT:  next_top = ~stack[0];
      SLTCU_OP_RISE: next_top = stack[0] & ~edge_mem[edge_slot];
      SLTCU_OP_FALL: next_top = ~stack[0] & edge_mem[edge_slot];
      default:       next_top = stack[0];
    endcase
  end

  // Operand error flag for the instruction just executed
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      operand_err <= 1'b0;
    end else if (ce && exec) begin
      unique case (op)
        SLTCU_OP_NOT, SLTCU_OP_RISE, SLTCU_OP_FALL: operand_err <= 1'b0;
        SLTCU_OP_TIMER, SLTCU_OP_COUNT:
          operand_err <= (windex1 > TC_NUM_MAX);
        SLTCU_OP_OUT, SLTCU_OP_SET, SLTCU_OP_RST:
          operand_err <= !bit_ok || (barea == SLTCU_A_IN) || (barea == SLTCU_A_FLAG);
        default:
          operand_err <= is_cmp ? !(w1_ok && w2_ok) : !bit_ok;
      endcase
    end
  end

  // Logic stack: loads push, combining ops rewrite the top
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stack <= '0;
    end else if (ce && exec) begin
      unique case (op)
        SLTCU_OP_LD, SLTCU_OP_LDN: begin
          if (bit_ok) begin
            stack <= {stack[STACK_DEPTH-2:0], next_top};
          end
        end
        SLTCU_OP_LDW_EQ, SLTCU_OP_LDW_GE, SLTCU_OP_LDW_LE: begin
          if (w1_ok && w2_ok) begin
            stack <= {stack[STACK_DEPTH-2:0], next_top};
          end
        end
        SLTCU_OP_AND, SLTCU_OP_OR, SLTCU_OP_ANDN, SLTCU_OP_ORN: begin
          if (bit_ok) begin
            stack[0] <= next_top;
          end
        end
        SLTCU_OP_AW_EQ, SLTCU_OP_AW_GE, SLTCU_OP_AW_LE,
        SLTCU_OP_OW_EQ, SLTCU_OP_OW_GE, SLTCU_OP_OW_LE: begin
          if (w1_ok && w2_ok) begin
            stack[0] <= next_top;
          end
        end
        SLTCU_OP_NOT, SLTCU_OP_RISE, SLTCU_OP_FALL: stack[0] <= next_top;
        default: stack <= stack;
      endcase
    end
  end

  // Edge memories hold the stack top seen at last execution
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      edge_mem <= '0;
    end else if (ce && exec && (op == SLTCU_OP_RISE || op == SLTCU_OP_FALL)) begin
      edge_mem[edge_slot] <= stack[0];
    end
  end

  // Output, set and reset on output and memory bits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_bits <= 4'h0;
      mem_bits <= 48'h0;
    end else if (ce && exec && bit_ok &&
                 (op == SLTCU_OP_OUT || op == SLTCU_OP_SET || op == SLTCU_OP_RST)) begin
      if (barea == SLTCU_A_OUT) begin
        out_bits[bbit[1:0]] <= (op == SLTCU_OP_OUT) ? stack[0] : (op == SLTCU_OP_SET);
      end else if (barea == SLTCU_A_MEM) begin
        mem_bits[{bbyte, bbit}] <= (op == SLTCU_OP_OUT) ? stack[0]
                                 : (op == SLTCU_OP_SET);
      end
    end
  end

  assign timer_sum = {1'b0, timer_val[tc_idx]} + {1'b0, elapsed};

  // Timers: add elapsed intervals per execution, saturate, clear when off
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_TC; i++) begin
        timer_val[i] <= WORD_RST;
      end
    end else if (ce && exec && op == SLTCU_OP_TIMER && windex1 <= TC_NUM_MAX) begin
      if (!stack[0]) begin
        timer_val[tc_idx] <= WORD_RST;
      end else if (timer_sum > {1'b0, TIMER_MAX}) begin
        timer_val[tc_idx] <= TIMER_MAX;
      end else begin
        timer_val[tc_idx] <= timer_sum[15:0];
      end
    end
  end

  // Counters: reset top, down second, up third; wraps naturally at 16 bits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_TC; i++) begin
        count_val[i] <= WORD_RST;
      end
      up_prev <= '0;
      dn_prev <= '0;
    end else if (ce && exec && op == SLTCU_OP_COUNT && windex1 <= TC_NUM_MAX) begin
      up_prev[tc_idx] <= stack[2];
      dn_prev[tc_idx] <= stack[1];
      if (stack[0]) begin
        count_val[tc_idx] <= WORD_RST;
      end else if (stack[2] && !up_prev[tc_idx] && !(stack[1] && !dn_prev[tc_idx])) begin
        count_val[tc_idx] <= count_val[tc_idx] + 16'h1;
      end else if (stack[1] && !dn_prev[tc_idx] && !(stack[2] && !up_prev[tc_idx])) begin
        count_val[tc_idx] <= count_val[tc_idx] - 16'h1;
      end
    end
  end

  // Current counter values presented as packed 16-bit signed words
  always_comb begin
    for (int i = 0; i < NUM_TC; i++) begin
      tc_values[i*16 +: 16] = count_val[i];
    end
  end

  assign stack_top = stack[0];

  a_timer_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_TIMER && windex1 <= TC_NUM_MAX && !stack[0])
    |=> timer_val[$past(tc_idx)] == 16'h0000)
    else $error("timer not cleared when disabled");

  a_timer_sat: assert property (@(posedge mclk) disable iff (!rst_b)
    timer_val[0] <= 16'h7FFF)
    else $error("timer above maximum");

  a_rise_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_RISE && stack[0] && !edge_mem[edge_slot]) |=> stack[0])
    else $error("rise pulse missed");

  a_fall_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_FALL && stack[0]) |=> !stack[0])
    else $error("fall pulse on high value");

  a_not_flip: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_NOT) |=> stack[0] != $past(stack[0]))
    else $error("invert did not flip");

  a_cnt_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_COUNT && windex1 == 3'h0 && !stack[0] && !stack[1]
     && stack[2] && !up_prev[0] && count_val[0] == 16'h7FFF) |=> count_val[0] == 16'h8000)
    else $error("counter did not wrap");

  a_cnt_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_COUNT && windex1 == 3'h1 && stack[0])
    |=> count_val[1] == 16'h0000)
    else $error("counter not reset");

  a_set_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_SET && barea == SLTCU_A_OUT && bbyte == 3'h0
     && bbit == 3'h2) |=> out_bits[2])
    else $error("set did not force output");

  a_range_io: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && exec && op == SLTCU_OP_LD && barea == SLTCU_A_IN && bbit > 3'h3)
    |=> operand_err && stack == $past(stack))
    else $error("out of range bit accepted");
endmodule // sltcu_core
`default_nettype wire

// ### verif/sltcu_plant.sv
/*
  Process image model: field input pins, flag bits and parameter words.
  Assumes the bench asks for new values; they change at a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sltcu_plant (
  input  wire logic        mclk,
  input  wire logic [3:0]  want_pins,
  input  wire logic [15:0] want_flags,
  input  wire logic [47:0] want_words,
  output logic      [3:0]  in_pins,
  output logic      [15:0] flag_bits,
  output logic      [47:0] parameter_words
);
  // Field wiring changes away from the sampling edge; settles long before reset ends
  always @(negedge mclk) begin
    in_pins         <= want_pins;
    flag_bits       <= want_flags;
    parameter_words <= want_words;
  end
endmodule // sltcu_plant
`default_nettype wire

// ### verif/tb_scan_logic_timer_counter_unit.sv
/*
  Self-checking bench for the scan logic, timer and counter unit.
  Assumes the core, the process image model and a shortened interval base.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_scan_logic_timer_counter_unit;
  import sltcu_pkg::*;
  localparam int unsigned TICKS = 10;
  logic         mclk, rst_b, ce, scan_start, exec, pend, stack_top, operand_err, t, r;
  sltcu_op_t    op;
  sltcu_barea_t barea;
  sltcu_warea_t warea1, warea2;
  logic [2:0]   bbyte, bbit, windex1, windex2, e;
  logic [15:0]  wconst, want_flags, flag_bits, seed, a, b;
  logic [4:0]   edge_slot;
  logic [3:0]   want_pins, in_pins, out_bits;
  logic [47:0]  want_words, parameter_words, mem_bits;
  logic [63:0]  tc_values;
  logic [2:0]   expq[$];
  int           mismatches, num_checks;

  sltcu_core #(.TICK_CYCLES(TICKS)) dut_u (.mclk, .rst_b, .ce, .scan_start, .exec, .op,
    .barea, .bbyte, .bbit, .warea1, .windex1, .warea2, .windex2, .wconst, .edge_slot,
    .in_pins, .flag_bits, .parameter_words, .out_bits, .mem_bits, .stack_top,
    .operand_err, .tc_values);
  sltcu_plant plant_u (.mclk, .want_pins, .want_flags, .want_words, .in_pins,
    .flag_bits, .parameter_words);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction

  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, g, x);
    end
  endtask

  // Launch an instruction; e holds {check top, top, refused}
  task automatic go(input sltcu_op_t o, input logic [2:0] x);
    op = o;
    exec = 1'b1;
    expq.push_back(x);
  endtask

  task automatic ex(input sltcu_op_t o, input sltcu_barea_t ar, input logic [2:0] by,
                    input logic [2:0] bi, input logic [2:0] x);
    @(negedge mclk);
    barea = ar;
    bbyte = by;
    bbit = bi;
    edge_slot = {2'h3, bi};
    go(o, x);
  endtask

  // Word operand 2 is always a constant here
  task automatic wx(input sltcu_op_t o, input sltcu_warea_t a1, input logic [2:0] i1,
                    input logic [15:0] c, input logic [2:0] x);
    @(negedge mclk);
    warea1 = a1;
    windex1 = i1;
    wconst = c;
    go(o, x);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge mclk);
      exec = 1'b0;
    end
  endtask

  task automatic scan();
    quiet(1);
    scan_start = 1'b1;
    @(negedge mclk);
    scan_start = 1'b0;
  endtask

  // M1.0 holds 1 and M1.1 holds 0, so each stack level is loaded from them
  task automatic cnt(input logic u, d, rs, input int n, input logic [15:0] x);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, {2'h0, ~u}, {1'b1, u, 1'b0});
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, {2'h0, ~d}, {1'b1, d, 1'b0});
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, {2'h0, ~rs}, {1'b1, rs, 1'b0});
    wx(SLTCU_OP_COUNT, SLTCU_W_CNT, n[2:0], 16'h0000, 3'h0);
    quiet(1);
    chk(tc_values[16*n+:16], x);
  endtask

  // Results are checked at the falling edge after the rising edge that took the instruction
  always @(posedge mclk) pend <= ce & exec;
  always @(negedge mclk) begin
    if (pend && expq.size() > 0) begin
      e = expq.pop_front();
      chk({15'h0, operand_err}, {15'h0, e[0]});
      if (e[2]) chk({15'h0, stack_top}, {15'h0, e[1]});
    end
  end

  // Whole run is a few hundred cycles; this only cuts a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    final_report();
  end

  initial begin
    {rst_b, scan_start, exec, edge_slot, bbyte, bbit, windex1, windex2} = '0;
    {wconst, want_pins, want_words} = '0;
    ce = 1'b1;
    op = SLTCU_OP_LD;
    barea = SLTCU_A_IN;
    warea1 = SLTCU_W_TIM;
    warea2 = SLTCU_W_CONST;
    want_flags = 16'h8000;
    seed = 16'h000D;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    chk({15'h0, |{mem_bits, tc_values, out_bits, stack_top, operand_err}}, 16'h0000);
    ex(SLTCU_OP_SET, SLTCU_A_MEM, 3'h1, 3'h0, 3'h0);
    ex(SLTCU_OP_SET, SLTCU_A_MEM, 3'h0, 3'h0, 3'h0);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h0, 3'h0, 3'h6);
    ex(SLTCU_OP_LDN, SLTCU_A_MEM, 3'h0, 3'h0, 3'h4);
    ex(SLTCU_OP_OR, SLTCU_A_MEM, 3'h0, 3'h0, 3'h6);
    ex(SLTCU_OP_ANDN, SLTCU_A_MEM, 3'h0, 3'h0, 3'h4);
    ex(SLTCU_OP_NOT, SLTCU_A_MEM, 3'h0, 3'h0, 3'h6);
    ex(SLTCU_OP_OUT, SLTCU_A_OUT, 3'h0, 3'h2, 3'h0);
    ex(SLTCU_OP_RST, SLTCU_A_MEM, 3'h0, 3'h0, 3'h0);
    quiet(1);
    chk({13'h0, out_bits[2], mem_bits[8], mem_bits[0]}, 16'h0006);
    ex(SLTCU_OP_RST, SLTCU_A_OUT, 3'h0, 3'h2, 3'h0);
    quiet(1);
    chk({15'h0, out_bits[2]}, 16'h0000);
    ex(SLTCU_OP_SET, SLTCU_A_OUT, 3'h0, 3'h2, 3'h0);
    quiet(1);
    chk({15'h0, out_bits[2]}, 16'h0001);
    // Edge memories: slot 31 for rising, slot 30 for falling
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h0, 3'h0, 3'h4);
    ex(SLTCU_OP_RISE, SLTCU_A_MEM, 3'h0, 3'h7, 3'h4);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, 3'h0, 3'h6);
    ex(SLTCU_OP_RISE, SLTCU_A_MEM, 3'h0, 3'h7, 3'h6);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, 3'h0, 3'h6);
    ex(SLTCU_OP_RISE, SLTCU_A_MEM, 3'h0, 3'h7, 3'h4);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, 3'h0, 3'h6);
    ex(SLTCU_OP_FALL, SLTCU_A_MEM, 3'h0, 3'h6, 3'h4);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, 3'h1, 3'h4);
    ex(SLTCU_OP_FALL, SLTCU_A_MEM, 3'h0, 3'h6, 3'h6);
    // Pin change must wait for the next scan start to reach the image
    want_pins = 4'h9;
    quiet(8);
    ex(SLTCU_OP_LD, SLTCU_A_IN, 3'h0, 3'h0, 3'h4);
    scan();
    ex(SLTCU_OP_LD, SLTCU_A_IN, 3'h0, 3'h3, 3'h6);
    ex(SLTCU_OP_LD, SLTCU_A_FLAG, 3'h1, 3'h7, 3'h6);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h5, 3'h7, 3'h4);
    ex(SLTCU_OP_LD, SLTCU_A_IN, 3'h0, 3'h4, 3'h5);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h6, 3'h0, 3'h5);
    ex(SLTCU_OP_LD, SLTCU_A_FLAG, 3'h2, 3'h0, 3'h5);
    ex(SLTCU_OP_OUT, SLTCU_A_OUT, 3'h0, 3'h4, 3'h5);
    ex(SLTCU_OP_SET, SLTCU_A_IN, 3'h0, 3'h0, 3'h5);
    wx(SLTCU_OP_LDW_EQ, SLTCU_W_TIM, 3'h4, 16'h0000, 3'h5);
    wx(SLTCU_OP_LDW_EQ, SLTCU_W_STORE, 3'h5, 16'h0000, 3'h5);
    wx(SLTCU_OP_LDW_EQ, SLTCU_W_PARAM, 3'h3, 16'h0000, 3'h5);
    wx(SLTCU_OP_COUNT, SLTCU_W_CNT, 3'h4, 16'h0000, 3'h1);
    wx(SLTCU_OP_LDW_EQ, SLTCU_W_STORE, 3'h4, 16'h0000, 3'h6);
    wx(SLTCU_OP_LDW_EQ, SLTCU_W_PARAM, 3'h2, 16'h0000, 3'h6);
    // Signed compares in load, and, or forms; first pair is the sign boundary
    for (int i = 0; i < 9; i++) begin
      // Wait for the last compare to be taken before the plant's word moves
      quiet(2);
      a = (i == 0) ? 16'h7FFF : rnd();
      b = (i == 0) ? 16'h8000 : (i % 2) ? a : rnd();
      want_words = {32'h0, a};
      t = (i % 3 == 1);
      if (i % 3 > 0) ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, {2'h0, ~t}, {1'b1, t, 1'b0});
      for (int k = 0; k < 3; k++) begin
        r = (k == 0) ? (a == b) : (k == 1) ? ($signed(a) >= $signed(b)) : ($signed(a) <= $signed(b));
        t = (i % 3 == 0) ? r : (i % 3 == 1) ? (t & r) : (t | r);
        wx(sltcu_op_t'(SLTCU_OP_LDW_EQ + 3 * (i % 3) + k), SLTCU_W_PARAM, 3'h0, b, {1'b1, t, 1'b0});
      end
    end
    cnt(1'b0, 1'b0, 1'b0, 0, 16'h0000);
    cnt(1'b1, 1'b0, 1'b0, 0, 16'h0001);
    cnt(1'b1, 1'b0, 1'b0, 0, 16'h0001);
    cnt(1'b0, 1'b0, 1'b0, 0, 16'h0001);
    cnt(1'b1, 1'b0, 1'b0, 0, 16'h0002);
    cnt(1'b0, 1'b1, 1'b0, 0, 16'h0001);
    cnt(1'b1, 1'b0, 1'b1, 0, 16'h0000);
    cnt(1'b0, 1'b1, 1'b0, 0, 16'hFFFF);
    cnt(1'b1, 1'b0, 1'b0, 3, 16'h0001);
    cnt(1'b1, 1'b0, 1'b0, 1, 16'h0001);
    cnt(1'b0, 1'b0, 1'b1, 1, 16'h0000);
    // Timer cleared, then one long scan gives 3 or 4 intervals per execution
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, 3'h1, 3'h4);
    wx(SLTCU_OP_TIMER, SLTCU_W_TIM, 3'h0, 16'h0000, 3'h0);
    scan();
    quiet(34);
    scan();
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, 3'h0, 3'h6);
    wx(SLTCU_OP_TIMER, SLTCU_W_TIM, 3'h0, 16'h0000, 3'h0);
    wx(SLTCU_OP_TIMER, SLTCU_W_TIM, 3'h0, 16'h0000, 3'h0);
    wx(SLTCU_OP_LDW_GE, SLTCU_W_TIM, 3'h0, 16'h0006, 3'h6);
    wx(SLTCU_OP_LDW_LE, SLTCU_W_TIM, 3'h0, 16'h0008, 3'h6);
    ex(SLTCU_OP_LD, SLTCU_A_MEM, 3'h1, 3'h1, 3'h4);
    wx(SLTCU_OP_TIMER, SLTCU_W_TIM, 3'h0, 16'h0000, 3'h0);
    wx(SLTCU_OP_LDW_EQ, SLTCU_W_TIM, 3'h0, 16'h0000, 3'h6);
    quiet(3);
    final_report();
  end
endmodule // tb_scan_logic_timer_counter_unit
`default_nettype wire
